//--- src/dag_defines.svh
// Constants of the DMA address generator: channels, codes, slots, fields
`ifndef DAG_DEFINES_SVH
`define DAG_DEFINES_SVH
`define DAG_AW       18
`define DAG_NCH      24
`define DAG_STEP     18'h00001
`define DAG_CH_BLT   5'h00
`define DAG_CH_DST   5'h03
`define DAG_CH_PLN   5'h04
`define DAG_CH_COP   5'h0A
`define DAG_CH_AUD   5'h0B
`define DAG_CH_SPR   5'h0F
`define DAG_CH_DSK   5'h17
`define DAG_RD_BLT   8'h20
`define DAG_RD_DST   8'h23
`define DAG_RD_COP   8'h30
`define DAG_RD_DSK   8'h38
`define DAG_RD_JMP   8'h3E
`define DAG_RD_PLN   8'h40
`define DAG_RD_AUD   8'h50
`define DAG_RD_SPR   8'h60
`define DAG_RD_IDLE  8'hFF
`define DAG_H_LAST   8'hE2
`define DAG_V_LAST   9'h106
`define DAG_AUD_SLOT 8'h0D
`define DAG_AUD_N    8'h04
`define DAG_DSK_SLOT 8'h07
`define DAG_DSK_N    8'h03
`define DAG_SPR_SLOT 8'h15
`define DAG_SPR_N    8'h10
`define DAG_DISP_H0  8'h38
`define DAG_DISP_H1  8'hD7
`define DAG_DISP_V0  9'h02C
`define DAG_DISP_V1  9'h0FF
`define DAG_SPR_VS8  2
`define DAG_SPR_VE8  1
`define DAG_SKIP_W   2'h2
`define DAG_LINE_PIX 16'h8000
`endif

//--- src/dag_pkg.sv
// Types shared by the DMA address generator modules
package dag_pkg;
  typedef enum logic [1:0] {
    dag_cop_w1   = 2'b00,
    dag_cop_w2   = 2'b01,
    dag_cop_exec = 2'b10,
    dag_cop_wait = 2'b11
  } dag_cop_st_t;
  typedef enum logic {
    dag_blt_idle = 1'b0,
    dag_blt_run  = 1'b1
  } dag_blt_st_t;
  typedef struct packed {
    logic [7:0]  minterm;
    logic [3:0]  ash;
    logic [3:0]  bsh;
    logic [2:0]  use_src;
    logic        line;
    logic        fill;
    logic        fill_excl;
    logic        fill_ci;
    logic [15:0] words;
  } dag_blt_cfg_t;
  typedef struct packed {
    logic [17:0] addr;
    logic [7:0]  dest;
    logic        act_n;
    logic        ram_wr;
    logic        reg_wr;
    logic        grp;
    logic [15:0] data;
  } dag_slot_t;
endpackage : dag_pkg

//--- src/dag_ptr_file.sv
// Channel pointer file with load port and wrapping advance port
`timescale 1ns/1ns
`include "dag_defines.svh"
module dag_ptr_file #(
  parameter int NCH = `DAG_NCH,
  parameter int AW  = `DAG_AW
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ld_en,
  input  wire logic [4:0]    ld_idx,
  input  wire logic [AW-1:0] ld_val,
  input  wire logic          adv_en,
  input  wire logic [4:0]    adv_idx,
  input  wire logic [AW-1:0] adv_dlt,
  input  wire logic [4:0]    rd_idx,
  output logic      [AW-1:0] rd_ptr
);
  logic [AW-1:0] ptr_w [NCH];

  // One pointer per channel; a load beats an advance on the same channel
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ptr
      logic [AW-1:0] ptr_r;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) ptr_r <= '0;
        else if (ld_en && ld_idx == 5'(g)) ptr_r <= ld_val;
        else if (adv_en && adv_idx == 5'(g)) ptr_r <= ptr_r + adv_dlt;
      end
      assign ptr_w[g] = ptr_r;
    end
  endgenerate

  // Unused indices read zero rather than out of range
  assign rd_ptr = (rd_idx < 5'(NCH)) ? ptr_w[rd_idx] : '0;
endmodule : dag_ptr_file

//--- src/dag_combiner.sv
// Image combiner: fetch A/B/C, shift, minterm logic, fill, write D
`timescale 1ns/1ns
`include "dag_defines.svh"
module dag_combiner
  import dag_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire dag_blt_cfg_t  cfg,
  input  wire logic          start,
  input  wire logic          gnt,
  input  wire logic [DW-1:0] din,
  output logic               req,
  output logic      [1:0]    src,
  output logic      [DW-1:0] dout,
  output logic               busy,
  output logic               done
);
  // First enabled source at or above s, 3 when none
  function automatic logic [1:0] nxt(input logic [2:0] u, input logic [1:0] s);
    logic [1:0] r;
    r = 2'h3;
    for (int i = 2; i >= 0; i--) if (u[i] && 2'(i) >= s) r = 2'(i);
    return r;
  endfunction : nxt

  // Area fill across a word, carry kept between words
  function automatic logic [DW:0] fillw(input logic [DW-1:0] d, input logic c0,
                                        input logic ex);
    logic c;
    logic [DW-1:0] o;
    c = c0;
    o = '0;
    for (int i = 0; i < DW; i++) begin
      o[i] = ex ? (d[i] ^ c) : (d[i] | c);
      c = c ^ d[i];
    end
    return {c, o};
  endfunction : fillw

  dag_blt_st_t   st_r;
  logic [1:0]    cur_r, psrc_r;
  logic          pend_r, dpend_r, fc_r, done_r;
  logic [15:0]   fl_r, wl_r;
  logic [DW-1:0] a_r, b_r, c_r, ao_r, bo_r, dbuf_r, res;
  logic [DW:0]   fres;

  wire run   = st_r == dag_blt_run;
  wire [1:0] first = nxt(cfg.use_src, 2'h0);
  wire [1:0] last  = cfg.use_src[2] ? 2'h2 : cfg.use_src[1] ? 2'h1 : 2'h0;
  wire none  = first == 2'h3;
  wire cmp   = (pend_r && psrc_r == last && !none) ||
               (run && none && !dpend_r && fl_r != 16'h0);
  // Next set overlaps the pending write; its last word waits for it
  wire fok   = run && !none && fl_r != 16'h0 && !((dpend_r || cmp) && cur_r == last);
  assign req = fok || (run && dpend_r);
  assign src = fok ? cur_r : 2'h3;
  wire [DW-1:0] a_n = (pend_r && psrc_r == 2'h0) ? din : a_r;
  wire [DW-1:0] b_n = (pend_r && psrc_r == 2'h1) ? din : b_r;
  wire [DW-1:0] c_n = (pend_r && psrc_r == 2'h2) ? din : c_r;
  wire [2*DW-1:0] a_cat = {ao_r, a_n} >> cfg.ash;
  wire [2*DW-1:0] b_cat = {bo_r, b_n} >> cfg.bsh;
  // Line mode draws one pixel from the shifted index, B is the texture
  wire [DW-1:0] a_u = cfg.line ? (`DAG_LINE_PIX >> cfg.ash) : a_cat[DW-1:0];
  wire [DW-1:0] b_u = cfg.line ? b_n : b_cat[DW-1:0];

  // Minterm select from the three source bits
  always_comb begin
    for (int i = 0; i < DW; i++) res[i] = cfg.minterm[{a_u[i], b_u[i], c_n[i]}];
    fres = cfg.fill ? fillw(res, fc_r, cfg.fill_excl) : {fc_r, res};
  end

  // Step sequencing; write grants count the task down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= dag_blt_idle;
      {cur_r, psrc_r, pend_r, dpend_r, fc_r, done_r} <= '0;
      {fl_r, wl_r, a_r, b_r, c_r, ao_r, bo_r, dbuf_r} <= '0;
    end else begin
      done_r <= 1'b0;
      pend_r <= gnt && src != 2'h3;
      if (pend_r) {a_r, b_r, c_r} <= {a_n, b_n, c_n};
      if (!run && start && cfg.words != 16'h0) begin
        st_r    <= dag_blt_run;
        {fl_r, wl_r} <= {cfg.words, cfg.words};
        cur_r   <= first;
        fc_r    <= cfg.fill_ci;
        dpend_r <= 1'b0;
        {ao_r, bo_r} <= '0;
      end else if (run) begin
        if (cmp) begin
          dbuf_r  <= fres[DW-1:0];
          fc_r    <= fres[DW];
          dpend_r <= 1'b1;
          {ao_r, bo_r} <= {a_n, b_n};
          if (none) fl_r <= fl_r - 16'h1;
        end
        if (gnt && src == 2'h3) begin
          dpend_r <= 1'b0;
          wl_r    <= wl_r - 16'h1;
          if (wl_r == 16'h1) begin
            st_r   <= dag_blt_idle;
            done_r <= 1'b1;
          end
        end else if (gnt) begin
          psrc_r <= cur_r;
          cur_r  <= (cur_r == last) ? first : nxt(cfg.use_src, cur_r + 2'h1);
          if (cur_r == last) fl_r <= fl_r - 16'h1;
        end
      end
    end
  end

  assign dout = dbuf_r;
  assign busy = run;
  assign done = done_r;
endmodule : dag_combiner

//--- src/dag_top.sv
// DMA address generator top: beam slots, arbitration, coproc, sprites
// What this block does
// - 18-bit pointer per channel drives address
// - Destination code driven with the address
// - Preloaded pointers advance after each transfer
// - Combiner loads A, B, C, writes D
// - 256 minterm functions plus barrel shift
// - Line draw and area fill modes
// - Combiner channels run unattended until done
// - Next fetch overlaps current logic step
// - Six plane channels fetch during display
// - Planes group into two images
// - Coproc pointer is its instruction counter
// - Move writes data to chosen register
// - Skip, jump, wait; wait stops fetching
// - Waiting copper requests no bus cycles
// - Wait ends when beam equals value
// - Four sound channels, blanking slots
// - Eight object channels, own slots each
// - Object: two data words, position words
// - Objects loaded by DMA
// - Objects reused further down screen
// - Disk channel moves up to 128K
// - Bus request asserted during DMA cycle
// - Slot, then priority, orders requests
// - Interrupt when combiner task completes
// - Slowdown input suspends combiner cycles
`timescale 1ns/1ns
`include "dag_defines.svh"
module dag_top
  import dag_pkg::*;
#(
  parameter int NCH = `DAG_NCH,
  parameter int AW  = `DAG_AW
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic          ptr_ld_en,
  input  wire logic [4:0]    ptr_ld_idx,
  input  wire logic [AW-1:0] ptr_ld_val,
  input  wire dag_blt_cfg_t  blt_cfg,
  input  wire logic          blt_start,
  input  wire logic          cop_run,
  input  wire logic [AW-1:0] cop_jump_addr,
  input  wire logic [2:0]    plane_count,
  input  wire logic          dual_image,
  input  wire logic [3:0]    audio_en,
  input  wire logic [7:0]    spr_en,
  input  wire logic          disk_len_ld,
  input  wire logic [16:0]   disk_len_val,
  input  wire logic          disk_wr,
  input  wire logic          external_dma_request,
  input  wire logic          combiner_slowdown_n,
  input  wire logic [15:0]   ram_rdata,
  output logic      [AW-1:0] memory_address_bus,
  output logic      [7:0]    register_destination_bus,
  output logic               bus_grant_request_n,
  output logic               ram_write,
  output logic               reg_write,
  output logic      [15:0]   bus_wdata,
  output logic               plane_group,
  output logic               combiner_done_irq_n
);
  // Slot window test, shared by the sound, disk and object slot groups
  function automatic logic in_rng(input logic [7:0] x, input logic [7:0] lo,
                                  input logic [7:0] n);
    return x >= lo && x < 8'(lo + n);
  endfunction : in_rng

  // Reset release through two flops
  logic rst_s1_r, rst_n_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) {rst_n_r, rst_s1_r} <= 2'h0;
    else {rst_n_r, rst_s1_r} <= {rst_s1_r, 1'b1};
  end

  // Pin synchronisers; only the second stage is read
  logic [1:0] ext_s_r, slow_s_r;
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ext_s_r  <= 2'h0;
      slow_s_r <= 2'h3;
    end else begin
      ext_s_r  <= {ext_s_r[0], external_dma_request};
      slow_s_r <= {slow_s_r[0], combiner_slowdown_n};
    end
  end
  wire ext_req  = ext_s_r[1];
  wire blt_hold = !slow_s_r[1];

  // Beam counter: one slot per clock
  logic [7:0] h_r;
  logic [8:0] v_r;
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      h_r <= 8'h00;
      v_r <= 9'h000;
    end else if (h_r == `DAG_H_LAST) begin
      h_r <= 8'h00;
      v_r <= (v_r == `DAG_V_LAST) ? 9'h000 : v_r + 9'h001;
    end else begin
      h_r <= h_r + 8'h01;
    end
  end
  wire frame_start = h_r == 8'h00 && v_r == 9'h000;
  wire [14:0] beam = {v_r[7:0], h_r[7:1]};

  // Return tag of the slot now on the bus
  logic       ret_v_r, ret_c_r, ret_w_r;
  logic [4:0] ret_ch_r;
  wire [15:0] din = ram_rdata;

  // Fixed slot decode
  wire [7:0] aud_off = h_r - `DAG_AUD_SLOT;
  wire [7:0] spr_off = h_r - `DAG_SPR_SLOT;
  wire [2:0] spr_i   = spr_off[3:1];
  wire [2:0] pln_i   = h_r[2:0];
  wire [7:0] spr_ctl, spr_want;
  logic [16:0] dsk_left_r;
  wire aud_rq = in_rng(h_r, `DAG_AUD_SLOT, `DAG_AUD_N) && ext_req &&
                audio_en[aud_off[1:0]];
  wire dsk_rq = in_rng(h_r, `DAG_DSK_SLOT, `DAG_DSK_N) && ext_req &&
                dsk_left_r != 17'h0;
  wire spr_rq = in_rng(h_r, `DAG_SPR_SLOT, `DAG_SPR_N) && spr_want[spr_i];
  wire pln_rq = v_r >= `DAG_DISP_V0 && v_r <= `DAG_DISP_V1 &&
                h_r >= `DAG_DISP_H0 && h_r <= `DAG_DISP_H1 &&
                pln_i < plane_count;
  wire fixed  = aud_rq || dsk_rq || spr_rq || pln_rq;

  // Free slots go to coproc first, then the combiner unless slowed
  dag_cop_st_t cop_st_r;
  logic        cop_pend_r;
  logic        blt_req, blt_done, blt_busy;
  logic [1:0]  blt_src;
  logic [15:0] blt_dout;
  wire cop_rq  = cop_run && !cop_pend_r && cop_st_r != dag_cop_wait;
  wire sel_cop = !fixed && cop_rq;
  wire sel_blt = !fixed && !cop_rq && blt_req && !blt_hold;
  wire cop_wr  = sel_cop && cop_st_r == dag_cop_exec;
  wire any     = fixed || sel_cop || sel_blt;
  wire blt_d   = blt_src == 2'h3;

  // Channel select in priority order
  wire [4:0] sel_ch = aud_rq ? `DAG_CH_AUD + aud_off[4:0] :
                      dsk_rq ? `DAG_CH_DSK :
                      spr_rq ? `DAG_CH_SPR + {2'h0, spr_i} :
                      pln_rq ? `DAG_CH_PLN + {2'h0, pln_i} :
                      sel_cop ? `DAG_CH_COP :
                      blt_d ? `DAG_CH_DST : `DAG_CH_BLT + {3'h0, blt_src};

  // Destination code for the selected channel
  logic [15:0] cop_w1_r, cop_w2_r;
  wire [7:0] sel_dest = aud_rq ? `DAG_RD_AUD + aud_off :
                        dsk_rq ? `DAG_RD_DSK :
                        spr_rq ? `DAG_RD_SPR + {3'h0, spr_i, !spr_ctl[spr_i],
                                                spr_off[0]} :
                        pln_rq ? `DAG_RD_PLN + {5'h00, pln_i} :
                        cop_wr ? cop_w1_r[8:1] :
                        sel_cop ? `DAG_RD_COP :
                        sel_blt ? `DAG_RD_BLT + {6'h00, blt_src} : `DAG_RD_IDLE;
  wire ram_xfer = any && !cop_wr;

  // Coproc decode of the returned second word
  logic [1:0] cop_skip_r;
  wire cop_ret  = ret_v_r && ret_ch_r == `DAG_CH_COP;
  wire cop_dec  = cop_ret && cop_st_r == dag_cop_w2;
  wire is_move  = !cop_w1_r[0];
  wire is_wait  = cop_w1_r[0] && !din[0];
  wire cop_jmp  = cop_dec && is_move && cop_w1_r[8:1] == `DAG_RD_JMP;

  logic [AW-1:0] rd_ptr;
  dag_ptr_file #(
    .NCH (NCH),
    .AW  (AW)
  ) u_ptr (
    .clk     (clk),
    .rst_n   (rst_n_r),
    .ld_en   (ptr_ld_en || cop_jmp),
    .ld_idx  (ptr_ld_en ? ptr_ld_idx : `DAG_CH_COP),
    .ld_val  (ptr_ld_en ? ptr_ld_val : cop_jump_addr),
    .adv_en  (ram_xfer),
    .adv_idx (sel_ch),
    .adv_dlt (`DAG_STEP),
    .rd_idx  (sel_ch),
    .rd_ptr  (rd_ptr)
  );

  dag_combiner u_blt (
    .clk   (clk),
    .rst_n (rst_n_r),
    .cfg   (blt_cfg),
    .start (blt_start),
    .gnt   (sel_blt),
    .din   (din),
    .req   (blt_req),
    .src   (blt_src),
    .dout  (blt_dout),
    .busy  (blt_busy),
    .done  (blt_done)
  );

  // Coproc: fetch two words, then move, wait or skip
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cop_st_r   <= dag_cop_w1;
      cop_pend_r <= 1'b0;
      cop_skip_r <= 2'h0;
      {cop_w1_r, cop_w2_r} <= '0;
    end else if (!cop_run) begin
      cop_st_r   <= dag_cop_w1;
      cop_pend_r <= 1'b0;
      cop_skip_r <= 2'h0;
    end else begin
      if (sel_cop && !cop_wr) cop_pend_r <= 1'b1;
      if (cop_wr) cop_st_r <= dag_cop_w1;
      if (cop_ret) cop_pend_r <= 1'b0;
      if (cop_ret && cop_st_r == dag_cop_w1) begin
        if (cop_skip_r != 2'h0) cop_skip_r <= cop_skip_r - 2'h1;
        else begin
          cop_w1_r <= din;
          cop_st_r <= dag_cop_w2;
        end
      end
      if (cop_dec) begin
        cop_w2_r <= din;
        if (is_move) cop_st_r <= cop_jmp ? dag_cop_w1 : dag_cop_exec;
        else if (is_wait) cop_st_r <= dag_cop_wait;
        else begin
          cop_st_r <= dag_cop_w1;
          if (beam >= cop_w1_r[15:1]) cop_skip_r <= `DAG_SKIP_W;
        end
      end
      if (cop_st_r == dag_cop_wait && beam == cop_w1_r[15:1])
        cop_st_r <= dag_cop_w1;
    end
  end

  // Moving objects: control pair sets lines, data pairs fill lines
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_spr
      logic       live_r, dph_r, pz_r;
      logic [8:0] vs_r, ve_r;
      wire hit = ret_v_r && ret_ch_r == `DAG_CH_SPR + 5'(g);
      assign spr_ctl[g]  = !dph_r || v_r == ve_r;
      assign spr_want[g] = live_r && spr_en[g] &&
                           (spr_ctl[g] || (v_r >= vs_r && v_r < ve_r));
      always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          {live_r, dph_r, pz_r} <= 3'h0;
          {vs_r, ve_r} <= '0;
        end else if (frame_start) begin
          live_r <= 1'b1;
          dph_r  <= 1'b0;
        end else if (hit && ret_c_r && !ret_w_r) begin
          vs_r <= {1'b0, din[15:8]};
          pz_r <= din == 16'h0;
        end else if (hit && ret_c_r) begin
          vs_r[8] <= din[`DAG_SPR_VS8];
          ve_r    <= {din[`DAG_SPR_VE8], din[15:8]};
          dph_r   <= 1'b1;
          if (pz_r && din == 16'h0) live_r <= 1'b0; // Zero pair ends the object
        end
      end
    end
  endgenerate

  // Slot staged for the bus; pointer read and code are one cycle
  dag_slot_t slot_nxt, slot_r;
  always_comb begin
    slot_nxt.addr   = rd_ptr;
    slot_nxt.dest   = sel_dest;
    slot_nxt.act_n  = !any;
    slot_nxt.ram_wr = (sel_blt && blt_d) || (dsk_rq && disk_wr);
    slot_nxt.reg_wr = cop_wr;
    slot_nxt.grp    = pln_rq && dual_image && pln_i[0];
    slot_nxt.data   = cop_wr ? cop_w2_r : blt_dout;
  end

  // Bus outputs and return tag
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      slot_r       <= '0;
      slot_r.act_n <= 1'b1;
      slot_r.dest  <= `DAG_RD_IDLE;
      {ret_v_r, ret_c_r, ret_w_r, ret_ch_r} <= '0;
    end else begin
      slot_r   <= slot_nxt;
      ret_v_r  <= ram_xfer && !slot_nxt.ram_wr;
      ret_ch_r <= sel_ch;
      ret_c_r  <= spr_ctl[spr_i];
      ret_w_r  <= spr_off[0];
    end
  end

  // Disk block length and combiner completion interrupt
  logic irq_n_r;
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dsk_left_r <= 17'h0;
      irq_n_r    <= 1'b1;
    end else begin
      if (disk_len_ld) dsk_left_r <= disk_len_val;
      else if (dsk_rq) dsk_left_r <= dsk_left_r - 17'h1;
      if (blt_done) irq_n_r <= 1'b0;
      else if (blt_start && !blt_busy) irq_n_r <= 1'b1;
    end
  end

  assign memory_address_bus       = slot_r.addr;
  assign register_destination_bus = slot_r.dest;
  assign bus_grant_request_n      = slot_r.act_n;
  assign ram_write                = slot_r.ram_wr;
  assign reg_write                = slot_r.reg_wr;
  assign bus_wdata                = slot_r.data;
  assign plane_group              = slot_r.grp;
  assign combiner_done_irq_n      = irq_n_r;
endmodule : dag_top

//--- verif/dag_top_monitor.sv
// Port-level checker of slot, destination and interrupt relations
`timescale 1ns/1ns
module dag_top_monitor
  import dag_pkg::*;
#(
  parameter int NCH = 24,
  parameter int AW  = 18
) (
  input wire logic          clk,
  input wire logic          resetn,
  input wire logic          cop_run,
  input wire logic [2:0]    plane_count,
  input wire logic          dual_image,
  input wire logic [3:0]    audio_en,
  input wire logic [7:0]    spr_en,
  input wire logic          external_dma_request,
  input wire logic          combiner_slowdown_n,
  input wire logic [7:0]    register_destination_bus,
  input wire logic          bus_grant_request_n,
  input wire logic          ram_write,
  input wire logic          reg_write,
  input wire logic          plane_group,
  input wire logic          combiner_done_irq_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Short names for the slot qualifier and destination code
  wire       slot = !bus_grant_request_n;
  wire [7:0] d    = register_destination_bus;

  AST_IDLE_CODE: assert property (!slot |-> d == 8'hFF)
    else $error("destination code not idle outside a slot");
  AST_WR_IN_SLOT: assert property ((ram_write || reg_write)
    |-> slot && !(ram_write && reg_write))
    else $error("write strobe outside a single slot");
  AST_PLANE_LIMIT: assert property (slot && d[7:4] == 4'h4 && $stable(plane_count)
    |-> d[3:0] < {1'b0, plane_count})
    else $error("plane slot beyond plane count");
  AST_PLANE_GROUP: assert property (slot && d[7:4] == 4'h4 && $stable(dual_image)
    |-> plane_group == (dual_image && d[0]))
    else $error("plane group marking wrong");
  AST_AUDIO_EN: assert property (slot && d[7:2] == 6'h14 && $stable(audio_en)
    |-> audio_en[d[1:0]])
    else $error("audio slot on a disabled channel");
  AST_SPRITE_EN: assert property (slot && d[7:5] == 3'h3 && $stable(spr_en)
    |-> spr_en[d[4:2]])
    else $error("sprite slot on a disabled object");
  AST_SLOW_HOLD: assert property ((!combiner_slowdown_n)[*4]
    |-> !(slot && d[7:2] == 6'h08))
    else $error("combiner slot while slowed down");
  AST_EXT_GATE: assert property ((!external_dma_request)[*4]
    |-> !(slot && (d[7:2] == 6'h14 || d == 8'h38)))
    else $error("external slot without request");
  AST_COP_OFF: assert property ((!cop_run)[*2] |-> !(slot && d == 8'h30) && !reg_write)
    else $error("coproc active while stopped");
  AST_IRQ_CAUSE: assert property ($fell(combiner_done_irq_n)
    |-> $past(d, 1) == 8'h23 || $past(d, 2) == 8'h23)
    else $error("done interrupt without destination write");
endmodule : dag_top_monitor

bind dag_top dag_top_monitor #(.NCH(NCH), .AW(AW)) u_dag_top_monitor (
  .clk(clk), .resetn(resetn), .cop_run(cop_run), .plane_count(plane_count),
  .dual_image(dual_image), .audio_en(audio_en), .spr_en(spr_en),
  .external_dma_request(external_dma_request), .combiner_slowdown_n(combiner_slowdown_n),
  .register_destination_bus(register_destination_bus),
  .bus_grant_request_n(bus_grant_request_n), .ram_write(ram_write),
  .reg_write(reg_write), .plane_group(plane_group),
  .combiner_done_irq_n(combiner_done_irq_n));

//--- verif/dag_ram_model.sv
// Behavioural shared RAM answering the DMA slots
`timescale 1ns/1ns
module dag_ram_model (
  input  wire logic        clk,
  input  wire logic        slot_n,
  input  wire logic [17:0] addr,
  input  wire logic        wr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata
);
  logic [15:0] mem [logic [17:0]];
  logic [15:0] last_r = 16'h0000;
  // Released bus shows the inverse of the last word, so stale data never matches
  always_comb rdata = slot_n ? ~last_r : (mem.exists(addr) ? mem[addr] : addr[15:0]);
  // Remember each answer and take DMA writes
  always @(posedge clk) begin
    if (!slot_n) last_r <= rdata;
    if (wr) mem[addr] = wdata;
  end
  task poke(input logic [17:0] a, input logic [15:0] v);
    mem[a] = v;
  endtask : poke
endmodule : dag_ram_model

//--- verif/dag_top_bench.sv
// Self-checking bench of the DMA address generator
`timescale 1ns/1ns
module dag_top_bench;
  import dag_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, ptr_ld_en = 1'b0, blt_start = 1'b0, cop_run = 1'b0;
  logic [4:0] ptr_ld_idx = 5'h00;
  logic [17:0] ptr_ld_val = 18'h00000, memory_address_bus;
  dag_blt_cfg_t blt_cfg = '0;
  logic [2:0] plane_count = 3'h0;
  logic dual_image = 1'b0, disk_len_ld = 1'b0, external_dma_request = 1'b0;
  logic [3:0] audio_en = 4'h0;
  logic [7:0] spr_en = 8'h00, register_destination_bus;
  logic [16:0] disk_len_val = 17'h00000;
  logic combiner_slowdown_n = 1'b1, bus_grant_request_n, ram_write, reg_write;
  logic plane_group, combiner_done_irq_n;
  logic [15:0] ram_rdata, bus_wdata;
  int bad_count = 0, checks = 0, disk_seen = 0;
  always #20 clk = ~clk;
  dag_top u_dag_top (.clk(clk), .resetn(resetn), .ptr_ld_en(ptr_ld_en),
    .ptr_ld_idx(ptr_ld_idx), .ptr_ld_val(ptr_ld_val), .blt_cfg(blt_cfg),
    .blt_start(blt_start), .cop_run(cop_run), .cop_jump_addr(18'h00000),
    .plane_count(plane_count), .dual_image(dual_image), .audio_en(audio_en),
    .spr_en(spr_en), .disk_len_ld(disk_len_ld), .disk_len_val(disk_len_val),
    .disk_wr(1'b0), .external_dma_request(external_dma_request),
    .combiner_slowdown_n(combiner_slowdown_n), .ram_rdata(ram_rdata),
    .memory_address_bus(memory_address_bus),
    .register_destination_bus(register_destination_bus),
    .bus_grant_request_n(bus_grant_request_n), .ram_write(ram_write),
    .reg_write(reg_write), .bus_wdata(bus_wdata), .plane_group(plane_group),
    .combiner_done_irq_n(combiner_done_irq_n));
  dag_ram_model u_dag_ram_model (.clk(clk), .slot_n(bus_grant_request_n),
    .addr(memory_address_bus), .wr(ram_write), .wdata(bus_wdata), .rdata(ram_rdata));
  // Disk slots are tallied all run long, since all three land in one line soon after the length load
  always @(negedge clk)
    if (bus_grant_request_n === 1'b0 && register_destination_bus === 8'h38) disk_seen++;
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      bad_count++;
      $display("unexpected wait expected completion seen none");
      close_out();
    end
  endtask : bound
  task automatic ld(input logic [4:0] i, input logic [17:0] v);
    ptr_ld_idx = i;
    ptr_ld_val = v;
    ptr_ld_en = 1'b1;
    @(negedge clk);
    ptr_ld_en = 1'b0;
    @(negedge clk);
  endtask : ld
  // One word step of the combiner, optionally held back by the slowdown input
  task automatic blt(input logic [17:0] pa, input logic [17:0] pd, input logic [7:0] mt,
                     input logic [15:0] exp, input logic slow);
    int n;
    blt_cfg.minterm = mt;
    combiner_slowdown_n = !slow;
    repeat (4) @(negedge clk);
    blt_start = 1'b1;
    @(negedge clk);
    blt_start = 1'b0;
    if (slow) begin
      repeat (40) @(negedge clk);
      chk("irq_n while slowed", 1, combiner_done_irq_n);
      combiner_slowdown_n = 1'b1;
    end
    n = 0;
    while (!(ram_write === 1'b1 && register_destination_bus === 8'h23) && n < 500) begin
      if (bus_grant_request_n === 1'b0 && register_destination_bus === 8'h20)
        chk("source A address", pa, memory_address_bus);
      @(negedge clk);
      n++;
    end
    bound(n, 500);
    chk("dest address", pd, memory_address_bus);
    chk("dest data", exp, bus_wdata);
    repeat (3) @(negedge clk);
    chk("irq_n after done", 0, combiner_done_irq_n);
    $display("test combiner done");
  endtask : blt
  // Move, then a wait on a far beam position, then a second move
  task automatic cop_test();
    int n;
    int fetches;
    logic seen;
    seen = 1'b0;
    u_dag_ram_model.poke(18'h01000, 16'h0100);
    u_dag_ram_model.poke(18'h01001, 16'hBEEF);
    u_dag_ram_model.poke(18'h01002, 16'h8001);
    u_dag_ram_model.poke(18'h01003, 16'h0000);
    u_dag_ram_model.poke(18'h01004, 16'h0102);
    u_dag_ram_model.poke(18'h01005, 16'h1111);
    ld(5'h0A, 18'h01000);
    cop_run = 1'b1;
    n = 0;
    while (reg_write !== 1'b1 && n < 3000) begin
      if (!seen && bus_grant_request_n === 1'b0 && register_destination_bus === 8'h30) begin
        chk("coproc first fetch", 32'h01000, memory_address_bus);
        seen = 1'b1;
      end
      @(negedge clk);
      n++;
    end
    bound(n, 3000);
    chk("move dest", 32'h80, register_destination_bus);
    chk("move data", 32'hBEEF, bus_wdata);
    repeat (40) @(negedge clk);
    fetches = 0;
    repeat (300) begin
      if (bus_grant_request_n === 1'b0 && register_destination_bus === 8'h30) fetches++;
      @(negedge clk);
    end
    chk("fetches while waiting", 0, fetches);
    n = 0;
    while (reg_write !== 1'b1 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    bound(n, 70000);
    chk("second move dest", 32'h81, register_destination_bus);
    chk("disk words moved", 3, disk_seen);
    $display("test coproc done");
  endtask : cop_test
  initial begin
    blt_cfg.use_src = 3'b001;
    blt_cfg.words = 16'h0001;
    repeat (10) @(negedge clk);
    chk("dest in reset", 32'hFF, register_destination_bus);
    chk("grant in reset", 1, bus_grant_request_n);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    $display("test reset done");
    plane_count = 3'h2;
    dual_image = 1'b1;
    audio_en = 4'h5;
    spr_en = 8'h03;
    external_dma_request = 1'b1;
    u_dag_ram_model.poke(18'h3FFFF, 16'h1234);
    u_dag_ram_model.poke(18'h00000, 16'hABCD);
    ld(5'h00, 18'h3FFFF);
    ld(5'h03, 18'h00010);
    disk_len_val = 17'h00003;
    disk_len_ld = 1'b1;
    @(negedge clk);
    disk_len_ld = 1'b0;
    blt(18'h3FFFF, 18'h00010, 8'hF0, 16'h1234, 1'b0);
    blt(18'h00000, 18'h00011, 8'h0F, 16'h5432, 1'b1);
    cop_test();
    close_out();
  end
endmodule : dag_top_bench
